/* File: verilog/cscr_core_regs.sv */
// core special-function register bank on the cpu io space
`timescale 1ns/100ps
module cscr_core_regs (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_addr,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_alu_upd,
   input  wire logic [3:0]  i_alu_mask,
   input  wire logic [3:0]  i_alu_flags,
   input  wire logic        i_sp_upd,
   input  wire logic [7:0]  i_sp_value,
   input  wire logic [5:0]  i_irq_events,
   input  wire logic        i_hrc_tick,
   input  wire logic        i_lrc_tick,
   input  wire logic        i_xtal_tick,
   input  wire logic        i_pin_a0,
   input  wire logic        i_pin_a4,
   input  wire logic        i_fast_boot,
   output logic [7:0]       o_rdata,
   output logic [3:0]       o_flags,
   output logic [7:0]       o_stack_ptr,
   output logic             o_hrc_en,
   output logic             o_lrc_en,
   output logic             o_wdt_en,
   output logic             o_rst_pin_sel,
   output logic [3:0]       o_sysclk_sel,
   output logic             o_irq_pending,
   output logic [15:0]      o_timer_count,
   output logic             o_fast_wake,
   output logic [11:0]      o_wake_clks
);
   logic [7:0]  flags_reg;
   logic [7:0]  sp_reg;
   logic [7:0]  clkmd_reg;
   logic [7:0]  ien_reg;
   logic [7:0]  irq_reg;
   logic [7:0]  wtm_reg;
   logic [7:0]  misc_reg;
   logic [7:0]  edge_reg;
   logic [1:0]  a0_sync_reg;
   logic [1:0]  a4_sync_reg;
   logic        a0_prev_reg;
   logic        a4_prev_reg;
   logic        fb_sync1_reg;
   logic        fb_reg;
   logic        tm_tick;
   logic        tm_event;
   logic [15:0] tm_count;
   logic [7:0]  irq_next;
   logic [7:0]  irq_set;

   // decode of the system clock choice; reserved codes yield SYSCLK_RSV
   function automatic logic [3:0] sysclk_decode(input logic [2:0] sel, input logic typ);
      logic [3:0] r;
      r = cscr_pkg::SYSCLK_RSV;
      if (!typ) begin
         case (sel)
            3'b000:  r = 4'h2;
            3'b001:  r = 4'h1;
            3'b110:  r = 4'hA;
            3'b111:  r = 4'h8;
            default: r = cscr_pkg::SYSCLK_RSV;
         endcase
      end else begin
         case (sel)
            3'b000:  r = 4'h4;
            3'b001:  r = 4'h3;
            3'b010:  r = 4'hC;
            3'b011:  r = 4'h5;
            3'b100:  r = 4'h6;
            default: r = cscr_pkg::SYSCLK_RSV;
         endcase
      end
      return r;
   endfunction

   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ref_addr, input logic w);
      return w && (a == ref_addr);
   endfunction

   // ************************************************************
   // pin and strap synchronisers
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         a0_sync_reg  <= 2'b00;
         a4_sync_reg  <= 2'b00;
         a0_prev_reg  <= 1'b0;
         a4_prev_reg  <= 1'b0;
         fb_sync1_reg <= 1'b0;
         fb_reg       <= 1'b0;
      end else begin
         a0_sync_reg  <= {a0_sync_reg[0], i_pin_a0};
         a4_sync_reg  <= {a4_sync_reg[0], i_pin_a4};
         a0_prev_reg  <= a0_sync_reg[1];
         a4_prev_reg  <= a4_sync_reg[1];
         fb_sync1_reg <= i_fast_boot;
         fb_reg       <= fb_sync1_reg;
      end
   end

   // ************************************************************
   // alu flags and stack pointer
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         flags_reg <= cscr_pkg::RST_FLAGS;
      end else if (i_alu_upd) begin
         // alu result wins over a same-cycle software write
         flags_reg <= ((flags_reg & ~{4'h0, i_alu_mask}) | {4'h0, i_alu_flags & i_alu_mask})
                      & cscr_pkg::MASK_FLAGS;
      end else if (wr_hit(i_addr, cscr_pkg::ADDR_FLAGS, i_wr)) begin
         flags_reg <= i_wdata & cscr_pkg::MASK_FLAGS;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sp_reg <= cscr_pkg::RST_STACK;
      end else if (wr_hit(i_addr, cscr_pkg::ADDR_STACK, i_wr)) begin
         sp_reg <= i_wdata;
      end else if (i_sp_upd) begin
         sp_reg <= i_sp_value;
      end
   end

   // ************************************************************
   // clock mode, timer mode, misc and edge select
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         clkmd_reg <= cscr_pkg::RST_CLKMD;
         wtm_reg   <= cscr_pkg::RST_WTM;
         misc_reg  <= cscr_pkg::RST_MISC;
         edge_reg  <= cscr_pkg::RST_EDGE;
         ien_reg   <= cscr_pkg::RST_IEN;
      end else begin
         // reserved codes are stored as written; sysclk decode flags them
         if (wr_hit(i_addr, cscr_pkg::ADDR_CLKMD, i_wr)) clkmd_reg <= i_wdata;
         if (wr_hit(i_addr, cscr_pkg::ADDR_WTM, i_wr))   wtm_reg   <= i_wdata;
         if (wr_hit(i_addr, cscr_pkg::ADDR_MISC, i_wr))  misc_reg  <= i_wdata & cscr_pkg::MASK_MISC;
         if (wr_hit(i_addr, cscr_pkg::ADDR_EDGE, i_wr))  edge_reg  <= i_wdata & cscr_pkg::MASK_EDGE;
         if (wr_hit(i_addr, cscr_pkg::ADDR_IEN, i_wr))   ien_reg   <= i_wdata;
      end
   end

   // ************************************************************
   // timer clock source and instance
   // ************************************************************
   always_comb begin
      case (wtm_reg[7:cscr_pkg::WTM_SRC_LO])
         cscr_pkg::CSCR_SRC_SYS:  tm_tick = 1'b1;
         cscr_pkg::CSCR_SRC_PA4:  tm_tick = a4_prev_reg & ~a4_sync_reg[1];
         cscr_pkg::CSCR_SRC_HRC:  tm_tick = i_hrc_tick & clkmd_reg[cscr_pkg::CLK_HRC];
         cscr_pkg::CSCR_SRC_XTAL: tm_tick = i_xtal_tick;
         cscr_pkg::CSCR_SRC_LRC:  tm_tick = i_lrc_tick & clkmd_reg[cscr_pkg::CLK_LRC];
         cscr_pkg::CSCR_SRC_PA0:  tm_tick = a0_prev_reg & ~a0_sync_reg[1];
         default:                 tm_tick = 1'b0;
      endcase
   end

   cscr_wide_timer u_timer (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_src      (wtm_reg[7:cscr_pkg::WTM_SRC_LO]),
      .i_div      (wtm_reg[cscr_pkg::WTM_SRC_LO-1:cscr_pkg::WTM_DIV_LO]),
      .i_bit_sel  (wtm_reg[2:0]),
      .i_falling  (edge_reg[cscr_pkg::EDGE_TM16]),
      .i_src_tick (tm_tick),
      .o_event    (tm_event),
      .o_count    (tm_count)
   );

   // ************************************************************
   // interrupt requests: set wins over a same-cycle clear
   // ************************************************************
   always_comb begin
      irq_set = 8'h00;
      irq_set[cscr_pkg::IRQ_TM8]  = i_irq_events[5];
      irq_set[cscr_pkg::IRQ_LPWM] = i_irq_events[4];
      irq_set[cscr_pkg::IRQ_CMP]  = i_irq_events[3];
      irq_set[cscr_pkg::IRQ_TM16] = i_irq_events[2] | tm_event;
      irq_set[cscr_pkg::IRQ_PIN1] = i_irq_events[1];
      irq_set[cscr_pkg::IRQ_PIN0] = i_irq_events[0];
      irq_next = irq_reg;
      if (wr_hit(i_addr, cscr_pkg::ADDR_IRQ, i_wr)) begin
         irq_next = i_wdata;
      end
      irq_next = (irq_next | irq_set) & cscr_pkg::MASK_IRQ;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_reg <= cscr_pkg::RST_IRQ;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // ************************************************************
   // read mux and registered outputs
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            cscr_pkg::ADDR_FLAGS: o_rdata <= flags_reg;
            cscr_pkg::ADDR_STACK: o_rdata <= sp_reg;
            cscr_pkg::ADDR_CLKMD: o_rdata <= clkmd_reg;
            cscr_pkg::ADDR_IEN:   o_rdata <= ien_reg;
            cscr_pkg::ADDR_IRQ:   o_rdata <= irq_reg;
            cscr_pkg::ADDR_WTM:   o_rdata <= wtm_reg;
            // misc and edge select are write-only
            default:              o_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flags       <= 4'h0;
         o_stack_ptr   <= 8'h00;
         o_hrc_en      <= 1'b1;
         o_lrc_en      <= 1'b1;
         o_wdt_en      <= 1'b1;
         o_rst_pin_sel <= 1'b0;
         o_sysclk_sel  <= 4'h8;
         o_irq_pending <= 1'b0;
         o_timer_count <= 16'h0000;
         o_fast_wake   <= 1'b0;
         o_wake_clks   <= 12'(cscr_pkg::NORMAL_WAKE_CLKS);
      end else begin
         o_flags       <= flags_reg[3:0];
         o_stack_ptr   <= sp_reg;
         o_hrc_en      <= clkmd_reg[cscr_pkg::CLK_HRC];
         o_lrc_en      <= clkmd_reg[cscr_pkg::CLK_LRC];
         // watchdog needs the low rc clock to run
         o_wdt_en      <= clkmd_reg[cscr_pkg::CLK_WDT] & clkmd_reg[cscr_pkg::CLK_LRC];
         o_rst_pin_sel <= clkmd_reg[cscr_pkg::CLK_RSTPIN];
         o_sysclk_sel  <= sysclk_decode(clkmd_reg[7:cscr_pkg::CLK_SEL_LO],
                                        clkmd_reg[cscr_pkg::CLK_TYPE]);
         o_irq_pending <= |(irq_reg & ien_reg);
         o_timer_count <= tm_count;
         // crystal conflict is left to software
         o_fast_wake   <= fb_reg | misc_reg[cscr_pkg::MISC_FAST];
         o_wake_clks   <= (fb_reg | misc_reg[cscr_pkg::MISC_FAST]) ? 12'(cscr_pkg::FAST_WAKE_CLKS)
                                                                   : 12'(cscr_pkg::NORMAL_WAKE_CLKS);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   // a write lands in the register, then one edge later in the output flop
   sequence seq_sp_write;
      wr_hit(i_addr, cscr_pkg::ADDR_STACK, i_wr);
   endsequence
   sequence seq_clk_write;
      wr_hit(i_addr, cscr_pkg::ADDR_CLKMD, i_wr);
   endsequence

   AST_IRQ_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_resetn)
      irq_set[cscr_pkg::IRQ_PIN0] |=> irq_reg[cscr_pkg::IRQ_PIN0])
      else $error("request lost");
   AST_IRQ_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (irq_reg[cscr_pkg::IRQ_CMP] && !wr_hit(i_addr, cscr_pkg::ADDR_IRQ, i_wr)) |=> irq_reg[cscr_pkg::IRQ_CMP])
      else $error("request dropped without write");
   AST_TM16_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
      tm_event |=> irq_reg[cscr_pkg::IRQ_TM16])
      else $error("timer event lost");
   AST_PENDING: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (|(irq_reg & ien_reg)) |=> o_irq_pending)
      else $error("enabled request not pending");

   AST_FLAGS_RSV: assert property (@(posedge i_clk) disable iff (!i_resetn)
      flags_reg[7:4] == 4'h0)
      else $error("reserved flag bits set");
   AST_FLAGS_ALU: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_alu_upd |=> (flags_reg[3:0] & $past(i_alu_mask)) == ($past(i_alu_flags) & $past(i_alu_mask)))
      else $error("alu flag update lost");
   AST_SP_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn)
      seq_sp_write |=> ##1 o_stack_ptr == $past(i_wdata, 2))
      else $error("stack pointer write lost");
   AST_RDATA_SP: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && i_addr == cscr_pkg::ADDR_STACK) |=> o_rdata == $past(sp_reg))
      else $error("stack pointer read wrong");

   AST_WDT_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !clkmd_reg[cscr_pkg::CLK_LRC] |=> !o_wdt_en)
      else $error("watchdog on without low rc");
   AST_CLK_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn)
      seq_clk_write |=> ##1 o_rst_pin_sel == $past(i_wdata[cscr_pkg::CLK_RSTPIN], 2))
      else $error("pin role write lost");
   AST_SYSCLK_T1: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (clkmd_reg[7:5] == 3'b100 && clkmd_reg[3]) |=> o_sysclk_sel == 4'h6)
      else $error("type 1 divide 64 decode wrong");
   AST_SYSCLK_T0: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (clkmd_reg[7:5] == 3'b111 && !clkmd_reg[3]) |=> o_sysclk_sel == 4'h8)
      else $error("type 0 low rc decode wrong");
   // reserved codes must stay visible to the clock generator
   AST_SYSCLK_RSV: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (clkmd_reg[7:5] == 3'b101 && clkmd_reg[3]) |=> o_sysclk_sel == cscr_pkg::SYSCLK_RSV)
      else $error("reserved clock code not flagged");

   AST_FAST_BOOT: assert property (@(posedge i_clk) disable iff (!i_resetn)
      fb_reg |=> o_fast_wake && o_wake_clks == 12'h02D)
      else $error("fast boot not forcing fast wake");
   AST_MISC_FAST: assert property (@(posedge i_clk) disable iff (!i_resetn)
      misc_reg[cscr_pkg::MISC_FAST] |=> o_fast_wake && o_wake_clks == 12'h02D)
      else $error("fast wake not taken");
   AST_WAKE_NORMAL: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!fb_reg && !misc_reg[cscr_pkg::MISC_FAST]) |=> o_wake_clks == 12'hBB8)
      else $error("normal wake count wrong");

   AST_TIMER_STOP: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wtm_reg[7:cscr_pkg::WTM_SRC_LO] == 3'b000 |=> $stable(tm_count))
      else $error("stopped timer counted");
endmodule

/* File: verilog/cscr_pkg.sv */
// package of offsets, fields and reset values for the core control register bank
package cscr_pkg;
   // ************************************************************
   // io addresses
   // ************************************************************
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_STACK = 8'h02;
   localparam logic [7:0] ADDR_CLKMD = 8'h03;
   localparam logic [7:0] ADDR_IEN   = 8'h04;
   localparam logic [7:0] ADDR_IRQ   = 8'h05;
   localparam logic [7:0] ADDR_WTM   = 8'h06;
   localparam logic [7:0] ADDR_MISC  = 8'h08;
   localparam logic [7:0] ADDR_EDGE  = 8'h0C;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int FLG_OV = 3;
   localparam int FLG_AC = 2;
   localparam int FLG_C  = 1;
   localparam int FLG_Z  = 0;
   localparam int CLK_SEL_LO = 5;
   localparam int CLK_HRC    = 4;
   localparam int CLK_TYPE   = 3;
   localparam int CLK_LRC    = 2;
   localparam int CLK_WDT    = 1;
   localparam int CLK_RSTPIN = 0;
   localparam int IRQ_TM8    = 6;
   localparam int IRQ_LPWM   = 5;
   localparam int IRQ_CMP    = 4;
   localparam int IRQ_TM16   = 2;
   localparam int IRQ_PIN1   = 1;
   localparam int IRQ_PIN0   = 0;
   localparam int WTM_SRC_LO = 5;
   localparam int WTM_DIV_LO = 3;
   localparam int MISC_FAST  = 5;
   localparam int EDGE_TM16  = 4;
   // ************************************************************
   // reset values and masks
   // ************************************************************
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_STACK = 8'h00;
   localparam logic [7:0] RST_CLKMD = 8'hF6;
   localparam logic [7:0] RST_IEN   = 8'h00;
   localparam logic [7:0] RST_IRQ   = 8'h00;
   localparam logic [7:0] RST_WTM   = 8'h00;
   localparam logic [7:0] RST_MISC  = 8'h00;
   localparam logic [7:0] RST_EDGE  = 8'h00;
   localparam logic [7:0] MASK_FLAGS = 8'h0F;
   localparam logic [7:0] MASK_IRQ   = 8'h77;
   localparam logic [7:0] MASK_MISC  = 8'h20;
   localparam logic [7:0] MASK_EDGE  = 8'h10;
   // ************************************************************
   // timer source and clock choice codes
   // ************************************************************
   typedef enum logic [2:0] {
      CSCR_SRC_OFF  = 3'b000,
      CSCR_SRC_SYS  = 3'b001,
      CSCR_SRC_RSV  = 3'b010,
      CSCR_SRC_PA4  = 3'b011,
      CSCR_SRC_HRC  = 3'b100,
      CSCR_SRC_XTAL = 3'b101,
      CSCR_SRC_LRC  = 3'b110,
      CSCR_SRC_PA0  = 3'b111
   } cscr_src_t;
   // system clock: bit 3 = low rc, bits 2:0 = log2 divider, 4'hF = reserved
   localparam logic [3:0] SYSCLK_RSV = 4'hF;
   localparam int NORMAL_WAKE_CLKS = 3000;
   localparam int FAST_WAKE_CLKS   = 45;
endpackage

/* File: verilog/cscr_wide_timer.sv */
// sixteen bit timer with source select, pre-divider and bit-toggle event
`timescale 1ns/100ps
module cscr_wide_timer (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [2:0]  i_src,
   input  wire logic [1:0]  i_div,
   input  wire logic [2:0]  i_bit_sel,
   input  wire logic        i_falling,
   input  wire logic        i_src_tick,
   output logic             o_event,
   output logic [15:0]      o_count
);
   logic [5:0]  pre_reg;
   logic [15:0] cnt_reg;
   logic        sel_prev_reg;
   logic        pre_hit;
   logic        sel_now;

   // ************************************************************
   // pre-divider
   // ************************************************************
   always_comb begin
      case (i_div)
         2'b00:   pre_hit = 1'b1;
         2'b01:   pre_hit = (pre_reg[1:0] == 2'h3);
         2'b10:   pre_hit = (pre_reg[3:0] == 4'hF);
         default: pre_hit = (pre_reg == 6'h3F);
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pre_reg <= 6'h00;
         cnt_reg <= 16'h0000;
      end else if (i_src != cscr_pkg::CSCR_SRC_OFF && i_src_tick) begin
         pre_reg <= pre_reg + 6'h01;
         if (pre_hit) begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end

   // ************************************************************
   // event on chosen bit transition
   // ************************************************************
   assign sel_now = cnt_reg[{1'b1, i_bit_sel}];

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_prev_reg <= 1'b0;
         o_event      <= 1'b0;
      end else begin
         sel_prev_reg <= sel_now;
         o_event      <= i_falling ? (sel_prev_reg & ~sel_now) : (~sel_prev_reg & sel_now);
      end
   end

   assign o_count = cnt_reg;
endmodule

/* File: dv/cscr_cpu_model.sv */
// cpu core model: io bus master plus oscillator ticks and pin toggles
`timescale 1ns/100ps
module cscr_cpu_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic [7:0]      o_addr,
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_wdata,
   output logic            o_hrc_tick,
   output logic            o_lrc_tick,
   output logic            o_xtal_tick,
   output logic            o_pin_a0,
   output logic            o_pin_a4
);
   logic [4:0] tick_cnt = 5'h00;
   initial begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   // ************************************************************
   // free running sources, distinct rates so a wrong source shows
   // ************************************************************
   always @(negedge i_clk) begin
      tick_cnt <= tick_cnt + 5'h01;
      o_hrc_tick <= tick_cnt[0];
      o_lrc_tick <= (tick_cnt[1:0] == 2'h3);
      o_xtal_tick <= (tick_cnt[2:0] == 3'h7);
      o_pin_a4 <= tick_cnt[3];
      o_pin_a0 <= tick_cnt[4];
   end
   // ************************************************************
   // io cycles: one strobe cycle, idle lines show inverted data
   // ************************************************************
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic io_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rdata;
   endtask
endmodule

/* File: dv/cscr_core_regs_tb.sv */
// self-checking bench for the core control register bank
`timescale 1ns/100ps
module cscr_core_regs_tb;
   localparam logic [3:0]  CLK_CODE [11] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h2, 4'hD};
   localparam logic [3:0]  CLK_SEL  [11] = '{4'h2, 4'h1, 4'hA, 4'h8, 4'h4, 4'h3, 4'hC, 4'h5, 4'h6, 4'hF, 4'hF};
   localparam logic [4:0]  RT_MODE  [10] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h00, 5'h10, 5'h18, 5'h14, 5'h0C, 5'h1C};
   localparam logic [15:0] RT_EXP   [10] = '{16'h0100, 16'h0040, 16'h0010, 16'h0004, 16'h0000,
                                             16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008};
   localparam int          EV_BIT   [6]  = '{0, 1, 2, 4, 5, 6};
   logic        i_clk, i_resetn, i_wr, i_rd, i_alu_upd, i_sp_upd, i_fast_boot;
   logic        i_hrc_tick, i_lrc_tick, i_xtal_tick, i_pin_a0, i_pin_a4;
   logic [7:0]  i_addr, i_wdata, i_sp_value, o_rdata, o_stack_ptr, wdat;
   logic [3:0]  i_alu_mask, i_alu_flags, o_flags, o_sysclk_sel;
   logic [5:0]  i_irq_events;
   logic        o_hrc_en, o_lrc_en, o_wdt_en, o_rst_pin_sel, o_irq_pending, o_fast_wake;
   logic [15:0] o_timer_count, c0, cnt, diff;
   logic [11:0] o_wake_clks;
   int          num_errors = 0;
   int          n_compared = 0;
   cscr_core_regs i_cscr_core_regs (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr),
      .i_rd(i_rd), .i_wdata(i_wdata), .i_alu_upd(i_alu_upd), .i_alu_mask(i_alu_mask),
      .i_alu_flags(i_alu_flags), .i_sp_upd(i_sp_upd), .i_sp_value(i_sp_value), .i_irq_events(i_irq_events),
      .i_hrc_tick(i_hrc_tick), .i_lrc_tick(i_lrc_tick), .i_xtal_tick(i_xtal_tick), .i_pin_a0(i_pin_a0),
      .i_pin_a4(i_pin_a4), .i_fast_boot(i_fast_boot), .o_rdata(o_rdata), .o_flags(o_flags),
      .o_stack_ptr(o_stack_ptr), .o_hrc_en(o_hrc_en), .o_lrc_en(o_lrc_en), .o_wdt_en(o_wdt_en),
      .o_rst_pin_sel(o_rst_pin_sel), .o_sysclk_sel(o_sysclk_sel), .o_irq_pending(o_irq_pending),
      .o_timer_count(o_timer_count), .o_fast_wake(o_fast_wake), .o_wake_clks(o_wake_clks));
   cscr_cpu_model i_cscr_cpu_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr),
      .o_rd(i_rd), .o_wdata(i_wdata), .o_hrc_tick(i_hrc_tick), .o_lrc_tick(i_lrc_tick),
      .o_xtal_tick(i_xtal_tick), .o_pin_a0(i_pin_a0), .o_pin_a4(i_pin_a4));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   // ************************************************************
   // access and compare tasks
   // ************************************************************
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_cscr_cpu_model.io_read(a, d);
      chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, d});
   endtask
   // derived outputs land one edge after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_cscr_cpu_model.io_write(a, d);
      repeat (2) @(negedge i_clk);
   endtask
   task automatic wait_pend();
      int n;
      n = 0;
      while (o_irq_pending !== 1'b1 && n < 5000) begin
         @(negedge i_clk);
         n++;
      end
      if (n == 5000) begin
         num_errors++;
         $display("[ERR] irq pending expected 1 seen timeout");
         stop_test();
      end
   endtask
   task automatic chk_defaults();
      rd_chk(cscr_pkg::ADDR_FLAGS, 8'h00);
      rd_chk(cscr_pkg::ADDR_STACK, 8'h00);
      rd_chk(cscr_pkg::ADDR_CLKMD, 8'hF6);
      rd_chk(cscr_pkg::ADDR_IEN, 8'h00);
      rd_chk(cscr_pkg::ADDR_IRQ, 8'h00);
      rd_chk(cscr_pkg::ADDR_WTM, 8'h00);
      chk("osc", 16'h0E08, {4'h0, o_hrc_en, o_lrc_en, o_wdt_en, o_rst_pin_sel, 4'h0, o_sysclk_sel});
      chk("wake", 16'h0BB8, {3'h0, o_fast_wake, o_wake_clks});
   endtask
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      i_resetn = 1'b0;
      i_alu_upd = 1'b0;
      i_alu_mask = 4'h0;
      i_alu_flags = 4'h0;
      i_sp_upd = 1'b0;
      i_sp_value = 8'h00;
      i_irq_events = 6'h00;
      i_fast_boot = 1'b0;
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      chk_defaults();
      wr(cscr_pkg::ADDR_FLAGS, 8'hFF);
      rd_chk(cscr_pkg::ADDR_FLAGS, 8'h0F);
      i_alu_upd = 1'b1;
      i_alu_mask = 4'h6;
      i_alu_flags = 4'h2;
      @(negedge i_clk);
      i_alu_upd = 1'b0;
      rd_chk(cscr_pkg::ADDR_FLAGS, 8'h0B);
      chk("flags", 16'h000B, {12'h000, o_flags});
      wr(cscr_pkg::ADDR_STACK, 8'h55);
      chk("sp", 16'h0055, {8'h00, o_stack_ptr});
      i_sp_upd = 1'b1;
      i_sp_value = 8'hAA;
      @(negedge i_clk);
      i_sp_upd = 1'b0;
      rd_chk(cscr_pkg::ADDR_STACK, 8'hAA);
      for (int k = 0; k < 11; k++) begin
         wdat = {CLK_CODE[k][2:0], 1'b1, CLK_CODE[k][3], 3'b110};
         wr(cscr_pkg::ADDR_CLKMD, wdat);
         chk("sysclk", {12'h000, CLK_SEL[k]}, {12'h000, o_sysclk_sel});
         rd_chk(cscr_pkg::ADDR_CLKMD, wdat);
      end
      wr(cscr_pkg::ADDR_CLKMD, 8'hE3);
      chk("osc", 16'h0001, {12'h000, o_hrc_en, o_lrc_en, o_wdt_en, o_rst_pin_sel});
      wr(cscr_pkg::ADDR_CLKMD, 8'hF5);
      chk("osc", 16'h000D, {12'h000, o_hrc_en, o_lrc_en, o_wdt_en, o_rst_pin_sel});
      for (int k = 0; k < 6; k++) begin
         i_irq_events = 6'h01 << k;
         @(negedge i_clk);
         i_irq_events = 6'h00;
         repeat (3) @(negedge i_clk);
         rd_chk(cscr_pkg::ADDR_IRQ, 8'h01 << EV_BIT[k]);
         chk("pending", 16'h0000, {15'h0000, o_irq_pending});
         wr(cscr_pkg::ADDR_IEN, 8'h01 << EV_BIT[k]);
         chk("pending", 16'h0001, {15'h0000, o_irq_pending});
         wr(cscr_pkg::ADDR_IRQ, 8'h00);
         chk("pending", 16'h0000, {15'h0000, o_irq_pending});
         wr(cscr_pkg::ADDR_IEN, 8'h00);
      end
      // rates over 256 cycles; pin sync and divider phase allow two counts of slack
      for (int k = 0; k < 10; k++) begin
         wr(cscr_pkg::ADDR_WTM, {RT_MODE[k], 3'h0});
         c0 = o_timer_count;
         repeat (256) @(negedge i_clk);
         diff = o_timer_count - c0;
         chk("timer rate", RT_EXP[k], (diff + 16'h0002 >= RT_EXP[k] && diff <= RT_EXP[k] + 16'h0002) ? RT_EXP[k] : diff);
      end
      wr(cscr_pkg::ADDR_IEN, 8'h04);
      for (int s = 0; s < 4; s++) begin
         if (s == 3) begin
            wr(cscr_pkg::ADDR_EDGE, 8'h10);
         end
         wr(cscr_pkg::ADDR_WTM, {5'b00100, s[2:0] & 3'h3});
         wr(cscr_pkg::ADDR_IRQ, 8'h00);
         wait_pend();
         cnt = o_timer_count;
         if (s == 3) begin
            chk("timer fall", 16'h0001, {15'h0000, cnt[11:0] < 12'h010});
         end else begin
            chk("timer rise", 16'h0001, {15'h0000, cnt[8+s] && (cnt & ((16'h0001 << (8 + s)) - 16'h0001)) < 16'h0010});
         end
      end
      rd_chk(cscr_pkg::ADDR_EDGE, 8'h00);
      wr(cscr_pkg::ADDR_MISC, 8'h20); // crystal is never enabled in this bench
      chk("wake", 16'h102D, {3'h0, o_fast_wake, o_wake_clks});
      rd_chk(cscr_pkg::ADDR_MISC, 8'h00);
      wr(cscr_pkg::ADDR_MISC, 8'h00);
      i_fast_boot = 1'b1;
      repeat (5) @(negedge i_clk);
      chk("wake", 16'h102D, {3'h0, o_fast_wake, o_wake_clks});
      i_fast_boot = 1'b0;
      wr(8'h01, 8'hFF);
      rd_chk(8'h01, 8'h00);
      @(negedge i_clk);
      i_resetn = 1'b0;
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      chk_defaults();
      stop_test();
   end
endmodule
